// >>> rtl/prs_pkg.sv
// package: register map, fields and types of the reference switchover block
package prs_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_LOOP_CTRL   = 8'h10;
  localparam logic [7:0] IDX_PFD_CTRL    = 8'h17;
  localparam logic [7:0] IDX_REF_CTRL    = 8'h1c;
  localparam logic [7:0] IDX_REF_SEL     = 8'h1d;
  localparam logic [7:0] IDX_PUMP_CUR    = 8'h30;
  localparam logic [7:0] IDX_STATUS      = 8'h31;

  // loop control fields
  localparam int LOOP_PWR_LSB   = 0;
  localparam int PUMP_MODE_LSB  = 4;
  localparam int PFD_POL_BIT    = 7;
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_ASYNC_DOWN = 2'h1;

  // pump mode codes
  localparam logic [2:0] PUMP_HIGHZ  = 3'h0;
  localparam logic [2:0] PUMP_UP     = 3'h1;
  localparam logic [2:0] PUMP_DOWN   = 3'h2;
  localparam logic [2:0] PUMP_NORMAL = 3'h3;

  // reference control fields
  localparam int REF_DIFF_SEL_BIT  = 0;
  localparam int REF_PRI_EN_BIT    = 1;
  localparam int REF_SEC_EN_BIT    = 2;
  localparam int REF_STAY_SEC_BIT  = 3;
  localparam int REF_AUTO_BIT      = 4;
  localparam int REF_USE_PIN_BIT   = 5;
  localparam int REF_DIFF_EN_BIT   = 6;
  localparam int REF_DEGLITCH_OFF_BIT = 7;

  // reset values
  localparam logic [7:0] RST_LOOP_CTRL = 8'h01;
  localparam logic [1:0] RST_ABL       = 2'h0;
  localparam logic [7:0] RST_REF_CTRL  = 8'h00;
  localparam logic       RST_REF_SEL   = 1'b0;
  localparam logic [2:0] RST_PUMP_CUR  = 3'h0;

  // detection counts
  localparam logic [1:0] MISS_FALLS    = 2'h2;
  localparam logic [2:0] RETURN_RISES  = 3'h4;

  // synchronised inputs
  localparam int IN_PRI   = 0;
  localparam int IN_SEC   = 1;
  localparam int IN_SEL   = 2;
  localparam int IN_RDIV  = 3;
  localparam int IN_NDIV  = 4;
  localparam int IN_COUNT = 5;

  typedef enum logic {AUTO_PRI, AUTO_SEC} prs_auto_type;

  typedef struct packed {
    logic       up;
    logic       down;
    logic       highZ;
    logic [2:0] current;
  } prs_pump_type;

  typedef struct packed {
    logic diffOn;
    logic priOn;
    logic secOn;
  } prs_buf_type;

endpackage

// >>> rtl/prs_ref_switch.sv
// reference selection, switchover, detector and pump control with bus slave
`timescale 1ns/1ps
module prs_ref_switch (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  input  wire logic              primaryRefPin,
  input  wire logic              secondaryRefPin,
  input  wire logic              refSelectPin,
  input  wire logic              refDividerOut,
  input  wire logic              fbDividerOut,
  output logic                   loopRef,
  output prs_pkg::prs_pump_type  pumpCmd,
  output prs_pkg::prs_buf_type   bufEnable,
  output logic                   primaryMissing
);
  import prs_pkg::*;

  // bus slave
  logic        wait_ff;
  logic        nxt_wait;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [7:0]  loopCtrl_ff;
  logic [1:0]  ablWidth_ff;
  logic [7:0]  refCtrl_ff;
  logic        regSel_ff;
  logic [2:0]  pumpCur_ff;

  wire [7:0] regIdx    = {2'h0, address[7:2]};
  wire       wrStrobe  = write & ~wait_ff & byteenable[0];
  wire       wrLoop    = wrStrobe & (regIdx == IDX_LOOP_CTRL);
  wire       wrPfd     = wrStrobe & (regIdx == IDX_PFD_CTRL);
  wire       wrRef     = wrStrobe & (regIdx == IDX_REF_CTRL);
  wire       wrSel     = wrStrobe & (regIdx == IDX_REF_SEL);
  wire       wrCur     = wrStrobe & (regIdx == IDX_PUMP_CUR);

  // one wait cycle, then the answer stands for one cycle
  assign nxt_wait = ~((read | write) & wait_ff);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0;
    end else begin
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loopCtrl_ff <= RST_LOOP_CTRL;
      ablWidth_ff <= RST_ABL;
      refCtrl_ff  <= RST_REF_CTRL;
      regSel_ff   <= RST_REF_SEL;
      pumpCur_ff  <= RST_PUMP_CUR;
    end else begin
      if (wrLoop)
        loopCtrl_ff <= writedata[7:0];
      if (wrPfd)
        ablWidth_ff <= writedata[1:0];
      if (wrRef)
        refCtrl_ff <= writedata[7:0];
      if (wrSel)
        regSel_ff <= writedata[0];
      if (wrCur)
        pumpCur_ff <= writedata[2:0];
    end
  end

  // control decode
  wire [1:0] loopPwr   = loopCtrl_ff[LOOP_PWR_LSB +: 2];
  wire [2:0] pumpMode  = loopCtrl_ff[PUMP_MODE_LSB +: 3];
  wire       pfdNeg    = loopCtrl_ff[PFD_POL_BIT];
  // only the normal code powers the loop
  wire       loopOn    = (loopPwr == PWR_NORMAL);
  wire       diffSel   = refCtrl_ff[REF_DIFF_SEL_BIT];
  wire       stayOnSec = refCtrl_ff[REF_STAY_SEC_BIT];
  wire       usePin    = refCtrl_ff[REF_USE_PIN_BIT];
  wire       deglOff   = refCtrl_ff[REF_DEGLITCH_OFF_BIT];
  wire       autoOn    = refCtrl_ff[REF_AUTO_BIT] & ~diffSel;
  wire       diffOn    = loopOn & diffSel & refCtrl_ff[REF_DIFF_EN_BIT];
  wire       priSeOn   = loopOn & ~diffSel & refCtrl_ff[REF_PRI_EN_BIT];
  wire       secSeOn   = loopOn & ~diffSel & refCtrl_ff[REF_SEC_EN_BIT];

  // pin synchronisers; the first stage feeds only the second
  logic [IN_COUNT-1:0] syncA_ff;
  logic [IN_COUNT-1:0] syncB_ff;
  wire  [IN_COUNT-1:0] pinIn = {fbDividerOut, refDividerOut, refSelectPin,
                                secondaryRefPin, primaryRefPin};

  genvar gi;
  generate
    for (gi = 0; gi < IN_COUNT; gi = gi + 1) begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          syncA_ff[gi] <= 1'b0;
          syncB_ff[gi] <= 1'b0;
        end else begin
          syncA_ff[gi] <= pinIn[gi];
          syncB_ff[gi] <= syncA_ff[gi];
        end
      end
    end
  endgenerate

  // gated levels and previous values for edge detection
  logic priPrev_ff;
  logic secPrev_ff;
  logic rPrev_ff;
  logic nPrev_ff;
  wire  priLvl  = syncB_ff[IN_PRI] & (priSeOn | diffOn);
  wire  secLvl  = syncB_ff[IN_SEC] & secSeOn;
  wire  priRise = priLvl & ~priPrev_ff;
  wire  priEdge = priLvl ^ priPrev_ff;
  wire  secRise = secLvl & ~secPrev_ff;
  wire  secFall = ~secLvl & secPrev_ff;
  wire  rRise   = syncB_ff[IN_RDIV] & ~rPrev_ff;
  wire  nRise   = syncB_ff[IN_NDIV] & ~nPrev_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      priPrev_ff <= 1'b0;
      secPrev_ff <= 1'b0;
      rPrev_ff   <= 1'b0;
      nPrev_ff   <= 1'b0;
    end else begin
      priPrev_ff <= priLvl;
      secPrev_ff <= secLvl;
      rPrev_ff   <= syncB_ff[IN_RDIV];
      nPrev_ff   <= syncB_ff[IN_NDIV];
    end
  end

  // missing and returning detection on the reference edges
  logic [1:0] missCnt_ff;
  logic [1:0] secSince_ff;
  logic [2:0] retCnt_ff;
  // two secondary falls, no primary edge
  wire        missHit  = (missCnt_ff == MISS_FALLS);
  // four primary rises, no double secondary fall
  wire        retHit   = (retCnt_ff == RETURN_RISES);
  wire        twoFalls = (secSince_ff == MISS_FALLS);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      missCnt_ff  <= 2'h0;
      secSince_ff <= 2'h0;
      retCnt_ff   <= 3'h0;
    end else begin
      if (priEdge)
        missCnt_ff <= 2'h0;
      else if (secFall && !missHit)
        missCnt_ff <= missCnt_ff + 2'h1;
      if (priRise)
        secSince_ff <= 2'h0;
      else if (secFall && !twoFalls)
        secSince_ff <= secSince_ff + 2'h1;
      if (priRise && twoFalls)
        retCnt_ff <= 3'h1;
      else if (priRise && !retHit)
        retCnt_ff <= retCnt_ff + 3'h1;
      else if (missHit)
        retCnt_ff <= 3'h0;
    end
  end

  // automatic selection state
  prs_auto_type autoState_ff;
  prs_auto_type nxt_autoState;

  always_comb begin
    nxt_autoState = autoState_ff;
    unique case (autoState_ff)
      AUTO_PRI: begin
        if (autoOn && missHit)
          nxt_autoState = AUTO_SEC;
      end
      AUTO_SEC: begin
        if (!autoOn)
          nxt_autoState = AUTO_PRI;
        else if (!stayOnSec && retHit)
          nxt_autoState = AUTO_PRI;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      autoState_ff <= AUTO_PRI;
    else
      autoState_ff <= nxt_autoState;
  end

  // manual selection registered from the synced select pin or the select register
  logic manSel_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      manSel_ff <= 1'b0;
    else
      manSel_ff <= usePin ? syncB_ff[IN_SEL] : regSel_ff;
  end

  // manual or automatic target; differential select forces primary
  wire target     = diffSel ? 1'b0 :
                    autoOn ? (autoState_ff == AUTO_SEC) : manSel_ff;
  wire targetRise = target ? secRise : priRise;

  // switchover: output held low until the target rises, unless deglitch is off in manual mode
  logic activeSel_ff;
  logic gate_ff;
  logic loopRef_ff;
  wire  pending   = (target != activeSel_ff);
  wire  immediate = ~autoOn & deglOff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      activeSel_ff <= 1'b0;
      gate_ff      <= 1'b0;
    end else if (pending && immediate) begin
      activeSel_ff <= target;
      gate_ff      <= 1'b0;
    end else if (pending && targetRise) begin
      // switch on the target's rising edge
      activeSel_ff <= target;
      gate_ff      <= 1'b0;
    end else if (pending) begin
      // deglitch holds edges; waits for target clock
      gate_ff      <= 1'b1;
    end else begin
      gate_ff      <= 1'b0;
    end
  end

  wire nxt_loopRef = (pending && !immediate && !targetRise) ? 1'b0 :
                     (pending ? (target ? secLvl : priLvl) :
                      (activeSel_ff ? secLvl : priLvl));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      loopRef_ff <= 1'b0;
    else
      loopRef_ff <= nxt_loopRef;
  end

  // phase frequency detector with antibacklash overlap
  logic       up_ff;
  logic       dn_ff;
  logic [1:0] ablCnt_ff;
  wire        bothOn = up_ff & dn_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_ff     <= 1'b0;
      dn_ff     <= 1'b0;
      ablCnt_ff <= 2'h0;
    end else if (!loopOn) begin
      up_ff     <= 1'b0;
      dn_ff     <= 1'b0;
      ablCnt_ff <= 2'h0;
    end else if (bothOn) begin
      // overlap lasts width field plus one cycles
      if (ablCnt_ff == ablWidth_ff) begin
        up_ff     <= 1'b0;
        dn_ff     <= 1'b0;
        ablCnt_ff <= 2'h0;
      end else begin
        ablCnt_ff <= ablCnt_ff + 2'h1;
      end
    end else begin
      up_ff <= up_ff | rRise;
      dn_ff <= dn_ff | nRise;
    end
  end

  // pump mode; negative polarity swaps directions
  wire pfdUp = pfdNeg ? dn_ff : up_ff;
  wire pfdDn = pfdNeg ? up_ff : dn_ff;
  wire modeNorm = loopOn & (pumpMode == PUMP_NORMAL);
  wire modeUp   = loopOn & (pumpMode == PUMP_UP);
  wire modeDn   = loopOn & (pumpMode == PUMP_DOWN);
  prs_pump_type nxt_pump;
  assign nxt_pump.up      = modeUp | (modeNorm & pfdUp);
  assign nxt_pump.down    = modeDn | (modeNorm & pfdDn);
  assign nxt_pump.highZ   = ~(modeNorm | modeUp | modeDn);
  assign nxt_pump.current = pumpCur_ff;

  prs_pump_type pump_ff;
  prs_buf_type  buf_ff;
  logic         missing_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_ff    <= '{up: 1'b0, down: 1'b0, highZ: 1'b1, current: 3'h0};
      buf_ff     <= '{diffOn: 1'b0, priOn: 1'b0, secOn: 1'b0};
      missing_ff <= 1'b0;
    end else begin
      pump_ff    <= nxt_pump;
      buf_ff     <= '{diffOn: diffOn, priOn: priSeOn, secOn: secSeOn};
      missing_ff <= missHit;
    end
  end

  // read mux; unmapped words read as zero
  wire [7:0] statusVal = {1'b0, buf_ff.secOn, buf_ff.priOn, buf_ff.diffOn,
                          gate_ff, (autoState_ff == AUTO_SEC), missing_ff,
                          activeSel_ff};
  wire [7:0] rdByte = (regIdx == IDX_LOOP_CTRL) ? loopCtrl_ff :
                      (regIdx == IDX_PFD_CTRL)  ? {6'h0, ablWidth_ff} :
                      (regIdx == IDX_REF_CTRL)  ? refCtrl_ff :
                      (regIdx == IDX_REF_SEL)   ? {7'h0, regSel_ff} :
                      (regIdx == IDX_PUMP_CUR)  ? {5'h0, pumpCur_ff} :
                      (regIdx == IDX_STATUS)    ? statusVal : 8'h00;
  assign nxt_rdata = (read && wait_ff) ? {24'h0, rdByte} : rdata_ff;

  assign readdata       = rdata_ff;
  assign waitrequest    = wait_ff;
  assign loopRef        = loopRef_ff;
  assign pumpCmd        = pump_ff;
  assign bufEnable      = buf_ff;
  assign primaryMissing = missing_ff;

endmodule

// >>> verification/prs_ref_src.sv
// partner: two reference sources and the select pin
`timescale 1ns/1ps
module prs_ref_src #(
  parameter int PRI_HALF = 8,
  parameter int SEC_HALF = 10
) (
  input  wire logic ref_clk,
  input  wire logic priRun,
  input  wire logic secRun,
  input  wire logic selLevel,
  output logic      primaryRefPin,
  output logic      secondaryRefPin,
  output logic      refSelectPin
);
  int priCnt_ff = 0;
  int secCnt_ff = 0;
  initial begin
    primaryRefPin   = 1'b0;
    secondaryRefPin = 1'b0;
    refSelectPin    = 1'b0;
  end
  always @(posedge ref_clk) begin
    refSelectPin <= selLevel;
    priCnt_ff    <= (priCnt_ff >= PRI_HALF - 1) ? 0 : priCnt_ff + 1;
    secCnt_ff    <= (secCnt_ff >= SEC_HALF - 1) ? 0 : secCnt_ff + 1;
    // a lost cmos source rests low, never floats
    if (!priRun) primaryRefPin <= 1'b0;
    else if (priCnt_ff == PRI_HALF - 1) primaryRefPin <= !primaryRefPin;
    if (!secRun) secondaryRefPin <= 1'b0;
    else if (secCnt_ff == SEC_HALF - 1) secondaryRefPin <= !secondaryRefPin;
  end
endmodule

// >>> verification/prs_ref_switch_chk.sv
// checker: bus, buffer, pump and switchover relations at the ports
`timescale 1ns/1ps
module prs_ref_switch_chk (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic [7:0]            address,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic [31:0]           writedata,
  input wire logic [3:0]            byteenable,
  input wire logic [31:0]           readdata,
  input wire logic                  waitrequest,
  input wire logic                  primaryRefPin,
  input wire logic                  secondaryRefPin,
  input wire logic                  refSelectPin,
  input wire logic                  refDividerOut,
  input wire logic                  fbDividerOut,
  input wire logic                  loopRef,
  input wire prs_pkg::prs_pump_type pumpCmd,
  input wire prs_pkg::prs_buf_type  bufEnable,
  input wire logic                  primaryMissing
);
  import prs_pkg::*;
  // shadow copies of the written controls; buffer, pump and missing outputs judged once settled
  logic [7:0] loopCtrl_ff;
  logic [7:0] refCtrl_ff;
  logic [2:0] pumpCur_ff;
  logic [1:0] quiet_ff;
  wire [5:0]  idx     = address[7:2];
  wire        wrHit   = write && !waitrequest && byteenable[0];
  wire        settled = quiet_ff == 2'h3;
  wire        pwrOn   = loopCtrl_ff[1:0] == PWR_NORMAL;
  wire [2:0]  mode    = loopCtrl_ff[6:4];
  wire        diffSel = refCtrl_ff[REF_DIFF_SEL_BIT];
  wire        mapped  = idx inside {IDX_LOOP_CTRL[5:0], IDX_PFD_CTRL[5:0],
    IDX_REF_CTRL[5:0], IDX_REF_SEL[5:0], IDX_PUMP_CUR[5:0], IDX_STATUS[5:0]};
  wire [1:0]  nxt_quiet = wrHit ? 2'h0 : (settled ? 2'h3 : quiet_ff + 2'h1);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loopCtrl_ff <= RST_LOOP_CTRL;
      refCtrl_ff  <= RST_REF_CTRL;
      pumpCur_ff  <= RST_PUMP_CUR;
      quiet_ff    <= 2'h0;
    end else begin
      quiet_ff <= nxt_quiet;
      if (wrHit && idx == IDX_LOOP_CTRL[5:0]) loopCtrl_ff <= writedata[7:0];
      if (wrHit && idx == IDX_REF_CTRL[5:0]) refCtrl_ff <= writedata[7:0];
      if (wrHit && idx == IDX_PUMP_CUR[5:0]) pumpCur_ff <= writedata[2:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_gated; ##2 !loopRef [*3]; endsequence
  property p_answer; (read || write) && waitrequest |=> !waitrequest;
  endproperty
  property p_single; !waitrequest |=> waitrequest; endproperty
  property p_unmapped; read && !waitrequest && !mapped |-> readdata == 0;
  endproperty
  property p_diffBuf; settled |-> bufEnable.diffOn ==
    (pwrOn && diffSel && refCtrl_ff[REF_DIFF_EN_BIT]); endproperty
  property p_seBuf; settled |->
    bufEnable.priOn == (pwrOn && !diffSel && refCtrl_ff[REF_PRI_EN_BIT]) &&
    bufEnable.secOn == (pwrOn && !diffSel && refCtrl_ff[REF_SEC_EN_BIT]);
  endproperty
  property p_pwrDown; settled && !pwrOn |-> bufEnable == 3'h0; endproperty
  property p_pumpMode;
    settled && pwrOn && !loopCtrl_ff[PFD_POL_BIT] && mode != PUMP_NORMAL
    |-> {pumpCmd.up, pumpCmd.down, pumpCmd.highZ} == {mode == PUMP_UP,
    mode == PUMP_DOWN, mode != PUMP_UP && mode != PUMP_DOWN}; endproperty
  property p_current; settled |-> pumpCmd.current == pumpCur_ff; endproperty
  property p_noMiss;
    settled && (!refCtrl_ff[REF_AUTO_BIT] || diffSel) |-> !primaryMissing;
  endproperty
  property p_missGate; $rose(primaryMissing) |-> s_gated; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  a_single: assert property (p_single) else $error("answer too long");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
  a_diffBuf: assert property (p_diffBuf) else $error("diff buffer");
  a_seBuf: assert property (p_seBuf) else $error("single buffer");
  a_pwrDown: assert property (p_pwrDown) else $error("loop off");
  a_pumpMode: assert property (p_pumpMode) else $error("pump mode");
  a_current: assert property (p_current) else $error("pump current");
  a_noMiss: assert property (p_noMiss) else $error("missing in manual");
  a_missGate: assert property (p_missGate) else $error("no gate");
endmodule
bind prs_ref_switch prs_ref_switch_chk u_chk (.ref_clk, .rst_n, .address,
  .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
  .primaryRefPin, .secondaryRefPin, .refSelectPin, .refDividerOut,
  .fbDividerOut, .loopRef, .pumpCmd, .bufEnable, .primaryMissing);

// >>> verification/tb_top.sv
// testbench: register and reference switchover scenarios
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  import prs_pkg::*;
  logic         ref_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic [7:0]   address = 8'h0;
  logic         read = 1'b0;
  logic         write = 1'b0;
  logic [31:0]  writedata = 32'h0;
  logic [31:0]  readdata;
  logic         waitrequest;
  logic         primaryRefPin;
  logic         secondaryRefPin;
  logic         refSelectPin;
  logic         refDividerOut = 1'b0;
  logic         fbDividerOut = 1'b0;
  logic         priRun = 1'b1;
  logic         secRun = 1'b1;
  logic         selLevel = 1'b0;
  logic         loopRef;
  logic         primaryMissing;
  prs_pump_type pumpCmd;
  prs_buf_type  bufEnable;
  logic [31:0]  rv;
  int           hiCnt;
  int           n_fail = 0;
  int           cmp_count = 0;
  logic [7:0]   bufCfg [4] = '{8'h02, 8'h47, 8'h46, 8'h06};
  logic [2:0]   bufExp [4] = '{3'h2, 3'h4, 3'h3, 3'h3};
  logic [2:0]   pumpExp [3] = '{3'h1, 3'h4, 3'h2};
  always #20 ref_clk = ~ref_clk;
  prs_ref_switch dut (.ref_clk, .rst_n, .address, .read, .write, .writedata,
    .byteenable(4'hf), .readdata, .waitrequest, .primaryRefPin,
    .secondaryRefPin, .refSelectPin, .refDividerOut, .fbDividerOut,
    .loopRef, .pumpCmd, .bufEnable, .primaryMissing);
  prs_ref_src u_src (.ref_clk, .priRun, .secRun, .selLevel, .primaryRefPin,
    .secondaryRefPin, .refSelectPin);
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic access(input logic wr, input logic [7:0] idx,
                        input logic [7:0] wd);
    int n;
    n = 0;
    address   <= {idx[5:0], 2'b00};
    writedata <= {24'h0, wd};
    write     <= wr;
    read      <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rv = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      n_fail++;
      stop_test();
    end
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    access(1'b1, idx, wd);
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] idx);
    access(1'b0, idx, 8'h0);
  endtask
  task automatic waitSig(input logic useRef, input logic ex, input int bound);
    int n;
    logic cur;
    n = 0;
    cur = useRef ? loopRef : primaryMissing;
    while (cur !== ex && n < bound) begin
      @(posedge ref_clk);
      n++;
      cur = useRef ? loopRef : primaryMissing;
    end
    `CHK("waited signal", ex, cur)
    if (cur !== ex) stop_test();
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    `CHK("bufEnable", 3'h0, bufEnable)
    `CHK("highZ", 1'b1, pumpCmd.highZ)
    rd(IDX_LOOP_CTRL);
    `CHK("loop ctrl", 32'h1, rv)
    rd(IDX_REF_CTRL);
    `CHK("ref ctrl", 32'h0, rv)
    rd(8'h3f);
    `CHK("unmapped", 32'h0, rv)
    $display("test reset done");
    wr(IDX_REF_CTRL, 8'h06);
    `CHK("bufEnable", 3'h0, bufEnable)
    // loop powered and set up by software before references are used
    wr(IDX_LOOP_CTRL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_REF_CTRL, bufCfg[i]);
      `CHK("bufEnable", bufExp[i], bufEnable)
    end
    wr(IDX_LOOP_CTRL, 8'h02);
    `CHK("bufEnable", 3'h0, bufEnable)
    $display("test buffers done");
    for (int m = 0; m < 3; m++) begin
      wr(IDX_LOOP_CTRL, {1'b0, 3'(m), 4'h0});
      `CHK("pump", pumpExp[m], {pumpCmd.up, pumpCmd.down, pumpCmd.highZ})
    end
    wr(IDX_LOOP_CTRL, 8'h30);
    refDividerOut <= 1'b1;
    repeat (5) @(posedge ref_clk);
    `CHK("up down", 2'h2, {pumpCmd.up, pumpCmd.down})
    fbDividerOut <= 1'b1;
    repeat (12) @(posedge ref_clk);
    `CHK("up down", 2'h0, {pumpCmd.up, pumpCmd.down})
    refDividerOut <= 1'b0;
    fbDividerOut  <= 1'b0;
    wr(IDX_PFD_CTRL, 8'h03);
    rd(IDX_PFD_CTRL);
    `CHK("antibacklash", 32'h3, rv)
    refDividerOut <= 1'b1;
    fbDividerOut  <= 1'b1;
    hiCnt = 0;
    repeat (20) begin
      @(posedge ref_clk);
      hiCnt += (pumpCmd.up === 1'b1 && pumpCmd.down === 1'b1);
    end
    `CHK("overlap cycles", 4, hiCnt)
    refDividerOut <= 1'b0;
    fbDividerOut  <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      wr(IDX_PUMP_CUR, 8'(c));
      `CHK("current", 3'(c), pumpCmd.current)
    end
    $display("test pump done");
    wr(IDX_REF_CTRL, 8'h16);
    repeat (60) @(posedge ref_clk);
    `CHK("primaryMissing", 1'b0, primaryMissing)
    priRun <= 1'b0;
    waitSig(1'b0, 1'b1, 100);
    waitSig(1'b1, 1'b1, 60);
    priRun <= 1'b1;
    waitSig(1'b0, 1'b0, 200);
    repeat (120) @(posedge ref_clk);
    rd(IDX_STATUS);
    `CHK("returned to primary", 2'h0, {rv[2], rv[0]})
    $display("test auto done");
    wr(IDX_REF_CTRL, 8'h1e);
    priRun <= 1'b0;
    waitSig(1'b0, 1'b1, 100);
    priRun <= 1'b1;
    repeat (150) @(posedge ref_clk);
    rd(IDX_STATUS);
    `CHK("on secondary", 1'b1, rv[2])
    wr(IDX_REF_CTRL, 8'h06);
    wr(IDX_REF_SEL, 8'h00);
    repeat (40) @(posedge ref_clk);
    rd(IDX_STATUS);
    `CHK("back on primary", 2'h0, {rv[2], rv[0]})
    wr(IDX_REF_CTRL, 8'h1e);
    repeat (40) @(posedge ref_clk);
    rd(IDX_STATUS);
    `CHK("auto on primary", 1'b0, rv[2])
    $display("test stay done");
    wr(IDX_REF_CTRL, 8'h06);
    wr(IDX_REF_SEL, 8'h01);
    repeat (60) @(posedge ref_clk);
    rd(IDX_STATUS);
    `CHK("reg select", 1'b1, rv[0])
    wr(IDX_REF_CTRL, 8'h26);
    for (int p = 0; p < 2; p++) begin
      selLevel <= 1'(p);
      repeat (60) @(posedge ref_clk);
      rd(IDX_STATUS);
      `CHK("pin select", 1'(p), rv[0])
    end
    selLevel <= 1'b0;
    repeat (60) @(posedge ref_clk);
    secRun   <= 1'b0;
    selLevel <= 1'b1;
    repeat (10) @(posedge ref_clk);
    hiCnt = 0;
    repeat (40) begin
      @(posedge ref_clk);
      hiCnt += (loopRef !== 1'b0);
    end
    `CHK("gated highs", 0, hiCnt)
    wr(IDX_REF_CTRL, 8'ha6);
    repeat (10) @(posedge ref_clk);
    rd(IDX_STATUS);
    `CHK("forced switch", 1'b1, rv[0])
    secRun <= 1'b1;
    waitSig(1'b1, 1'b1, 100);
    $display("test manual done");
    wr(IDX_REF_CTRL, 8'h57);
    priRun <= 1'b0;
    repeat (100) @(posedge ref_clk);
    `CHK("primaryMissing", 1'b0, primaryMissing)
    priRun <= 1'b1;
    $display("test differential done");
    stop_test();
  end
endmodule
